// >>> ntbr_consts.svh
`ifndef NTBR_CONSTS_SVH
`define NTBR_CONSTS_SVH
// Register byte offsets.
`define NTBR_OFS_SETUP 12'h09c
`define NTBR_OFS_CTL 12'h0a0
`define NTBR_OFS_DATA 12'h0a4
`define NTBR_OFS_STS 12'h0a8
// Fixed part of the fourth window's setup register.
`define NTBR_SETUP_SIZE 6'h0c
`define NTBR_SETUP_EN_BIT 31
// Control register fields.
`define NTBR_CTL_WR_MASK 32'h8ffffffc
`define NTBR_CTL_KIND_BIT 30
`define NTBR_CTL_OP_BIT 31
// Status register fields.
`define NTBR_STS_BUSY_BIT 0
`define NTBR_STS_DONE_BIT 1
`define NTBR_STS_ABORT_BIT 5
`define NTBR_STS_CAP_BIT 31
// Completion codes.
`define NTBR_CPL_SC 3'h0
`define NTBR_CPL_UR 3'h1
`define NTBR_CPL_CRS 3'h2
`define NTBR_CPL_CA 3'h3
`define NTBR_CPL_RA 3'h4
// Reset values.
`define NTBR_RST_WORD 32'h00000000
`define NTBR_RST_STS 3'h0
`endif

// >>> ntbr_pkg.sv
package ntbr_pkg;
  // Transaction engine states.
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} ntbr_state_t;
  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } ntbr_apb_req_t;
  // APB answer to the master.
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ntbr_apb_rsp_t;
  // Far-side configuration request.
  typedef struct packed {
    logic write;
    logic access_kind;
    logic [7:0] bus;
    logic [4:0] target_device;
    logic [2:0] target_function;
    logic [3:0] target_ext_reg_number;
    logic [5:0] reg_number;
    logic [3:0] byte_en;
    logic [31:0] data;
  } ntbr_req_t;
  // Far-side completion.
  typedef struct packed {
    logic [2:0] status;
    logic [31:0] data;
  } ntbr_cpl_t;
endpackage : ntbr_pkg

// >>> ntbr_passthru_regs.sv
// Notes on behaviour
// - Window setup space-kind bit is read-only zero, memory space.
// - Window setup bits 2:1 read-only zero, 32-bit addressing.
// - Window setup bit 3 read-only zero, non-prefetchable.
// - Window setup bits 9:4 read fixed 0xC, a 4KB window.
// - Setup bit 31 enables the window; when zero the window is off.
// - Enable, target fields, operation and data survive hot resets.
// - Control bits 7:2 register number, 11:8 extended register number.
// - Control bits 14:12 function, 19:15 device, 27:20 bus.
// - Control bit 30 picks type 0 or type 1 access.
// - Control bit 31 picks read (0) or write (1).
// - A data register write while idle launches one far-side transaction.
// - Far-side byte enables equal the launching write's strobes.
// - Write operation sends the written value as payload.
// - Read operation ignores written value, stores returned data.
// - Status busy bit is high while a transaction runs.
// - Done flag set on finish; write one clears it or aborts.
// - Three-bit completion status valid while done is set.
// - Capability bit; without it other fields read zero.
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`include "ntbr_consts.svh"
module ntbr_passthru_regs
  import ntbr_pkg::*;
#(
  parameter bit CAPABLE = 1'b1
) (
  // Clock and resets.
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic por_n_i,
  // APB slave.
  input wire ntbr_apb_req_t apb_i,
  output ntbr_apb_rsp_t apb_o,
  // Far-side request.
  output logic req_valid_o,
  output ntbr_req_t req_o,
  input wire logic req_ready_i,
  // Far-side completion and abort.
  input wire logic cpl_valid_i,
  input wire ntbr_cpl_t cpl_i,
  output logic abort_o,
  // Window enable towards the base address register.
  output logic window4_enable_o
);

  // Reset synchronisers; assertion is asynchronous, release is clocked.
  logic rst_meta;
  logic rst_n;
  logic por_meta;
  logic por_n;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // The power-on reset clears the state that hot resets must spare.
  always_ff @(posedge clock_i or negedge por_n_i) begin
    if (!por_n_i) begin
      por_meta <= 1'b0;
      por_n <= 1'b0;
    end else begin
      por_meta <= 1'b1;
      por_n <= por_meta;
    end
  end

  // Sticky state.
  logic win_en;
  logic [31:0] ctl;
  logic [31:0] data;
  logic done;
  logic [2:0] sts;
  logic aborted;
  logic next_win_en;
  logic [31:0] next_ctl;
  logic [31:0] next_data;
  logic next_done;
  logic [2:0] next_sts;
  logic next_aborted;

  // State cleared by the hot reset only.
  ntbr_state_t state;
  ntbr_state_t next_state;
  logic access_kind;
  logic next_access_kind;
  logic next_req_valid;
  ntbr_req_t next_req;
  logic next_abort;
  logic next_win_out;
  ntbr_apb_rsp_t next_apb;

  // Bus decode shared by both groups.
  logic setup_ph;
  logic wr_acc;
  logic sel_setup;
  logic sel_ctl;
  logic sel_data;
  logic sel_sts;
  logic mapped;
  logic busy;
  logic launch;
  logic cpl_take;
  logic abort_ev;
  logic [31:0] rd_word;

  // Merge write data into a word lane by lane under the strobes.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wdat[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // The access phase with pready high is the one edge a write acts on.
  assign setup_ph = apb_i.psel && !apb_i.penable;
  assign wr_acc = apb_i.psel && apb_i.penable && apb_o.pready &&
                  apb_i.pwrite;
  assign sel_setup = (apb_i.paddr == `NTBR_OFS_SETUP);
  assign sel_ctl = (apb_i.paddr == `NTBR_OFS_CTL);
  assign sel_data = (apb_i.paddr == `NTBR_OFS_DATA);
  assign sel_sts = (apb_i.paddr == `NTBR_OFS_STS);
  assign mapped = sel_setup || sel_ctl || sel_data || sel_sts;
  assign busy = (state != ST_IDLE);

  // A launch while busy is dropped; software must wait for done.
  assign launch = CAPABLE && wr_acc && sel_data && !busy;
  assign cpl_take = (state == ST_WAIT) && cpl_valid_i;
  assign abort_ev = wr_acc && sel_sts && apb_i.pstrb[0] &&
                    apb_i.pwdata[`NTBR_STS_DONE_BIT] && busy;

  // Read word, built at the setup phase and held in the answer flop.
  always_comb begin
    rd_word = `NTBR_RST_WORD;
    if (sel_setup) begin
      rd_word[0] = 1'b0;
      rd_word[2:1] = 2'b00;
      rd_word[3] = 1'b0;
      rd_word[9:4] = `NTBR_SETUP_SIZE;
      rd_word[`NTBR_SETUP_EN_BIT] = win_en;
    end else if (sel_ctl && CAPABLE) begin
      rd_word = ctl & `NTBR_CTL_WR_MASK;
      rd_word[`NTBR_CTL_KIND_BIT] = access_kind;
    end else if (sel_data && CAPABLE) begin
      rd_word = data;
    end else if (sel_sts) begin
      if (CAPABLE) begin
        rd_word[`NTBR_STS_BUSY_BIT] = busy;
        rd_word[`NTBR_STS_DONE_BIT] = done;
        rd_word[4:2] = sts;
        rd_word[`NTBR_STS_ABORT_BIT] = aborted;
      end
      rd_word[`NTBR_STS_CAP_BIT] = CAPABLE;
    end
  end

  // Sticky next values: window enable, control, data and completion.
  always_comb begin
    next_win_en = win_en;
    next_ctl = ctl;
    next_data = data;
    next_done = done;
    next_sts = sts;
    next_aborted = aborted;
    if (wr_acc && sel_setup && apb_i.pstrb[3]) begin
      next_win_en = apb_i.pwdata[`NTBR_SETUP_EN_BIT];
    end
    if (wr_acc && sel_ctl && CAPABLE) begin
      // Reserved bits and the non-sticky kind bit are masked off.
      next_ctl = merge(ctl, apb_i.pwdata, apb_i.pstrb) &
                 `NTBR_CTL_WR_MASK;
    end
    if (launch) begin
      next_aborted = 1'b0;
      if (ctl[`NTBR_CTL_OP_BIT]) begin
        next_data = merge(data, apb_i.pwdata, apb_i.pstrb);
      end
    end
    // Clear first, so a completion in the same cycle wins.
    if (wr_acc && sel_sts && apb_i.pstrb[0] &&
        apb_i.pwdata[`NTBR_STS_DONE_BIT]) begin
      next_done = 1'b0;
    end
    if (cpl_take) begin
      next_done = 1'b1;
      next_sts = cpl_i.status;
      if (!ctl[`NTBR_CTL_OP_BIT]) begin
        next_data = cpl_i.data;
      end
    end
    if (abort_ev) begin
      next_done = 1'b1;
      next_sts = `NTBR_CPL_RA;
      next_aborted = 1'b1;
    end
  end

  // Sticky registers see only the power-on reset.
  always_ff @(posedge clock_i or negedge por_n) begin
    if (!por_n) begin
      win_en <= 1'b0;
      ctl <= `NTBR_RST_WORD;
      data <= `NTBR_RST_WORD;
      done <= 1'b0;
      sts <= `NTBR_RST_STS;
      aborted <= 1'b0;
    end else begin
      win_en <= next_win_en;
      ctl <= next_ctl;
      data <= next_data;
      done <= next_done;
      sts <= next_sts;
      aborted <= next_aborted;
    end
  end

  // Engine, request port and bus answer.
  always_comb begin
    next_state = state;
    next_access_kind = access_kind;
    next_req_valid = req_valid_o;
    next_req = req_o;
    next_abort = 1'b0;
    next_win_out = win_en;
    next_apb = apb_o;
    if (wr_acc && sel_ctl && CAPABLE && apb_i.pstrb[3]) begin
      next_access_kind = apb_i.pwdata[`NTBR_CTL_KIND_BIT];
    end
    // No wait state: answer prepared at setup, shown in the first access cycle.
    next_apb.pready = setup_ph && !apb_o.pready;
    next_apb.pslverr = setup_ph && !apb_o.pready && !mapped;
    if (setup_ph && !apb_o.pready) begin
      next_apb.prdata = apb_i.pwrite ? `NTBR_RST_WORD : rd_word;
    end
    case (state)
      ST_IDLE: begin
        if (launch) begin
          next_state = ST_REQ;
          next_req_valid = 1'b1;
          next_req.write = ctl[`NTBR_CTL_OP_BIT];
          next_req.access_kind = access_kind;
          next_req.bus = ctl[27:20];
          next_req.target_device = ctl[19:15];
          next_req.target_function = ctl[14:12];
          next_req.target_ext_reg_number = ctl[11:8];
          next_req.reg_number = ctl[7:2];
          next_req.byte_en = apb_i.pstrb;
          next_req.data = ctl[`NTBR_CTL_OP_BIT] ?
                          apb_i.pwdata : `NTBR_RST_WORD;
        end
      end
      ST_REQ: begin
        if (req_ready_i) begin
          next_state = ST_WAIT;
          next_req_valid = 1'b0;
        end
      end
      ST_WAIT: begin
        if (cpl_valid_i) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_req_valid = 1'b0;
      end
    endcase
    // Abort beats any progress in the same cycle.
    if (abort_ev) begin
      next_state = ST_IDLE;
      next_req_valid = 1'b0;
      next_abort = 1'b1;
    end
  end

  // Registers cleared by the hot reset only.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      access_kind <= 1'b0;
      req_valid_o <= 1'b0;
      req_o <= '0;
      abort_o <= 1'b0;
      window4_enable_o <= 1'b0;
      apb_o <= '0;
    end else begin
      state <= next_state;
      access_kind <= next_access_kind;
      req_valid_o <= next_req_valid;
      req_o <= next_req;
      abort_o <= next_abort;
      window4_enable_o <= next_win_out;
      apb_o <= next_apb;
    end
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  logic rd_setup;
  logic rd_ctl;
  assign rd_setup = setup_ph && !apb_o.pready && !apb_i.pwrite &&
                    sel_setup;
  assign rd_ctl = setup_ph && !apb_o.pready && !apb_i.pwrite && sel_ctl;

  sequence s_launch;
    launch ##1 req_valid_o;
  endsequence

  // A handoff that an abort in the same cycle does not override.
  sequence s_handoff;
    req_valid_o && req_ready_i && !abort_ev;
  endsequence

  property p_space_kind;
    rd_setup |=> apb_o.pready && apb_o.prdata[0] == 1'b0;
  endproperty
  a_space_kind: assert property (p_space_kind)
    else $error("window space kind not memory");

  property p_addr_type;
    rd_setup |=> apb_o.prdata[2:1] == 2'b00;
  endproperty
  a_addr_type: assert property (p_addr_type)
    else $error("window address type not 32-bit");

  property p_prefetch;
    rd_setup |=> apb_o.prdata[3] == 1'b0;
  endproperty
  a_prefetch: assert property (p_prefetch)
    else $error("window reported prefetchable");

  property p_size;
    rd_setup |=> apb_o.prdata[9:4] == 6'h0c && apb_o.prdata[30:10] == '0;
  endproperty
  a_size: assert property (p_size)
    else $error("window size field wrong");

  property p_enable;
    wr_acc && sel_setup && apb_i.pstrb[3] |=>
      ##1 window4_enable_o == $past(apb_i.pwdata[31], 2);
  endproperty
  a_enable: assert property (p_enable)
    else $error("window enable did not follow write");

  property p_launch;
    s_launch |-> req_o.byte_en == $past(apb_i.pstrb) &&
                 req_o.write == $past(ctl[31]);
  endproperty
  a_launch: assert property (p_launch)
    else $error("launched request fields wrong");

  property p_handoff;
    s_handoff |=> state == ST_WAIT && !req_valid_o;
  endproperty
  a_handoff: assert property (p_handoff)
    else $error("request not handed off");

  property p_busy;
    launch |=> busy [*2];
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy not raised after launch");

  property p_done;
    cpl_take |=> done && sts == $past(cpl_i.status) && !busy;
  endproperty
  a_done: assert property (p_done)
    else $error("completion not recorded");

  property p_abort;
    abort_ev |=> done && sts == 3'h4 && abort_o && !req_valid_o;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort not recorded");

  property p_reserved;
    rd_ctl |=> apb_o.prdata[1:0] == 2'b00 && apb_o.prdata[29:28] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits not zero");

endmodule : ntbr_passthru_regs

// >>> ntbr_far_model.sv
`timescale 1ns/100ps
// Behavioural configuration target on the far side of the bridge.
module ntbr_far_model
  import ntbr_pkg::*;
(
  // Clock.
  input wire logic clock_i,
  // Request from the bridge.
  input wire logic req_valid_i,
  input wire ntbr_req_t req_i,
  output logic req_ready_o,
  // Completion back to the bridge.
  output logic cpl_valid_o,
  output ntbr_cpl_t cpl_o,
  // Knobs set by the bench.
  input wire logic [7:0] delay_i,
  input wire logic [2:0] status_i,
  input wire logic [31:0] rdata_i,
  output ntbr_req_t seen_o
);
  logic busy = 1'b0;
  logic [7:0] cnt = 8'h00;
  ntbr_req_t seen_q = '0;

  initial begin
    req_ready_o = 1'b0;
    cpl_valid_o = 1'b0;
    cpl_o = '0;
  end

  // Accept after delay_i cycles, answer after delay_i more. Completion
  // data toggles outside its pulse, so a sample one cycle late never matches.
  always @(posedge clock_i) begin
    req_ready_o <= 1'b0;
    cpl_valid_o <= 1'b0;
    cpl_o.data <= ~cpl_o.data;
    if (!busy) begin
      if (req_valid_i && !req_ready_o) begin
        if (cnt == delay_i) begin
          req_ready_o <= 1'b1;
          seen_q <= req_i;
          busy <= 1'b1;
          cnt <= 8'h00;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end else begin
        cnt <= 8'h00;
      end
    end else if (cnt == delay_i) begin
      cpl_valid_o <= 1'b1;
      cpl_o <= '{status: status_i, data: rdata_i};
      busy <= 1'b0;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  assign seen_o = seen_q;
endmodule : ntbr_far_model

// >>> testbench.sv
`timescale 1ns/100ps
`include "ntbr_consts.svh"
module testbench;
  import ntbr_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic por_n_i = 1'b0;
  ntbr_apb_req_t apb_req = '0;
  ntbr_apb_rsp_t apb_rsp;
  ntbr_req_t req, seen;
  ntbr_cpl_t cpl;
  logic req_valid, req_ready, cpl_valid, abort_pulse, win_en;
  logic [7:0] delay = 8'h02;
  logic [2:0] cpl_status = 3'h0;
  logic [31:0] cpl_data = 32'h0;
  int num_errors = 0;
  int compares = 0;
  int handoffs = 0;
  int aborts = 0;

  ntbr_passthru_regs dut_u (.clock_i(clock_i), .nrst_i(nrst_i),
    .por_n_i(por_n_i), .apb_i(apb_req), .apb_o(apb_rsp),
    .req_valid_o(req_valid), .req_o(req), .req_ready_i(req_ready),
    .cpl_valid_i(cpl_valid), .cpl_i(cpl), .abort_o(abort_pulse),
    .window4_enable_o(win_en));
  ntbr_far_model far_u (.clock_i(clock_i), .req_valid_i(req_valid),
    .req_i(req), .req_ready_o(req_ready), .cpl_valid_o(cpl_valid),
    .cpl_o(cpl), .delay_i(delay), .status_i(cpl_status),
    .rdata_i(cpl_data), .seen_o(seen));

  // Clock at 250 MHz.
  always #2 clock_i = ~clock_i;

  // Count handoffs and abort pulses seen at the far side.
  always @(posedge clock_i) begin
    if (req_valid === 1'b1 && req_ready === 1'b1) handoffs++;
    if (abort_pulse === 1'b1) aborts++;
  end

  task automatic end_sim;
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] q, output logic e);
    int n = 0;
    @(posedge clock_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                 pwdata: d, pstrb: s};
    @(posedge clock_i);
    apb_req.penable <= 1'b1;
    // Answer is taken at the rising edge that sees pready high.
    do begin
      @(posedge clock_i);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (apb_rsp.pready !== 1'b1) begin
      num_errors++;
      end_sim();
    end
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, s, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, 4'h0, q, e);
    check(q, x);
  endtask : rd

  // Software polls the done flag before touching the result.
  task automatic wait_done;
    logic [31:0] q;
    logic e;
    int n = 0;
    do begin
      apb(1'b0, `NTBR_OFS_STS, 32'h0, 4'h0, q, e);
      n++;
    end while (q[1] !== 1'b1 && n < 40);
    if (q[1] !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask : wait_done

  task automatic test_layout;
    logic [31:0] q;
    logic e;
    rd(`NTBR_OFS_SETUP, 32'h000000c0);
    rd(`NTBR_OFS_CTL, 32'h0);
    rd(`NTBR_OFS_STS, 32'h80000000);
    wr(`NTBR_OFS_SETUP, 32'hffffffff, 4'hf);
    rd(`NTBR_OFS_SETUP, 32'h800000c0);
    check(win_en, 1'b1);
    wr(`NTBR_OFS_CTL, 32'hffffffff, 4'hf);
    rd(`NTBR_OFS_CTL, 32'hcffffffc);
    apb(1'b0, 12'h0b0, 32'h0, 4'h0, q, e);
    check({e, q}, 33'h100000000);
  endtask : test_layout

  // Write operation: payload, strobes and target fields reach the far side.
  task automatic test_write_op;
    logic [31:0] ctl = {2'b11, 2'b00, 8'h5a, 5'h13, 3'h5, 4'ha, 6'h2d, 2'b00};
    int h0 = handoffs;
    wr(`NTBR_OFS_CTL, ctl, 4'hf);
    rd(`NTBR_OFS_CTL, ctl);
    wr(`NTBR_OFS_DATA, 32'h12345678, 4'hf);
    wait_done();
    check(seen, {1'b1, 1'b1, 8'h5a, 5'h13, 3'h5, 4'ha, 6'h2d, 4'hf,
                 32'h12345678});
    check(handoffs - h0, 1);
    rd(`NTBR_OFS_STS, 32'h80000002);
    rd(`NTBR_OFS_DATA, 32'h12345678);
    wr(`NTBR_OFS_STS, 32'h2, 4'hf);
    rd(`NTBR_OFS_STS, 32'h80000000);
  endtask : test_write_op

  // Read operation for completion codes SC, UR, CRS and CA from the far side.
  task automatic test_read_op;
    logic [31:0] ctl = {2'b00, 2'b00, 8'h03, 5'h1f, 3'h7, 4'h0, 6'h01, 2'b00};
    for (int i = 0; i < 4; i++) begin
      cpl_status <= 3'(i);
      cpl_data <= 32'ha5a50000 | 32'(i);
      wr(`NTBR_OFS_CTL, ctl, 4'hf);
      wr(`NTBR_OFS_DATA, 32'hffffffff, 4'h6);
      wait_done();
      check(seen, {2'b00, 8'h03, 5'h1f, 3'h7, 4'h0, 6'h01, 4'h6,
                   32'h0});
      rd(`NTBR_OFS_DATA, 32'ha5a50000 | 32'(i));
      rd(`NTBR_OFS_STS, 32'h80000002 | 32'(i << 2));
      wr(`NTBR_OFS_STS, 32'h2, 4'hf);
    end
  endtask : test_read_op

  // Abort while the far side stalls the request.
  task automatic test_abort;
    int a0 = aborts;
    delay <= 8'hff;
    wr(`NTBR_OFS_DATA, 32'h0, 4'hf);
    // Status field still holds the last completion code, three.
    rd(`NTBR_OFS_STS, 32'h8000000d);
    wr(`NTBR_OFS_STS, 32'h2, 4'hf);
    rd(`NTBR_OFS_STS, 32'h80000032);
    check(aborts - a0, 1);
    check(req_valid, 1'b0);
    wr(`NTBR_OFS_STS, 32'h2, 4'hf);
    rd(`NTBR_OFS_STS, 32'h80000030);
    delay <= 8'h01;
    wr(`NTBR_OFS_DATA, 32'h0, 4'hf);
    wait_done();
    // Far side still answers with code three; the abort flag clears.
    rd(`NTBR_OFS_STS, 32'h8000000e);
  endtask : test_abort

  // Hot reset keeps sticky fields; the access kind bit clears.
  task automatic test_hot_reset;
    wr(`NTBR_OFS_SETUP, 32'h80000000, 4'hf);
    wr(`NTBR_OFS_CTL, 32'hc5a5a5a4, 4'hf);
    wr(`NTBR_OFS_STS, 32'h2, 4'hf);
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    check(win_en, 1'b1);
    rd(`NTBR_OFS_SETUP, 32'h800000c0);
    rd(`NTBR_OFS_CTL, 32'h85a5a5a4);
    rd(`NTBR_OFS_DATA, 32'ha5a50003);
    wr(`NTBR_OFS_SETUP, 32'h0, 4'hf);
    // The enable output follows the sticky bit one cycle later.
    repeat (2) @(posedge clock_i);
    check(win_en, 1'b0);
  endtask : test_hot_reset

  // Main sequence: power-on reset for ten cycles, then the scenarios.
  initial begin
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    por_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    test_layout();
    test_write_op();
    test_read_op();
    test_hot_reset();
    test_abort();
    end_sim();
  end
endmodule : testbench
